// File: hdl/dsa_arbiter.sv
// direction shift arbiter with apb configuration
`timescale 1ns/10ps
`default_nettype none
module dsa_arbiter
    import dsa_pkg::*;
#(
    parameter int unsigned NUM_GEARS = NUM_GEARS_DEF,
    parameter int unsigned BRAKE_CYC = BRAKE_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] lever_dir,
    input wire logic [2:0] lever_range,
    input wire logic [15:0] vehicle_speed,
    input wire logic [15:0] engine_speed,
    input wire logic [7:0] throttle_pct,
    input wire logic standstill,
    input wire logic overspeed_free,
    input wire logic range_up,
    input wire logic range_dn,
    output logic [1:0] dir_out,
    output logic [2:0] gear_out,
    output logic warn_lamp,
    output logic brake_dn,
    output logic spd_lim_req
);
    localparam int CNT_W = $clog2(BRAKE_CYC + 1);
    localparam logic [CNT_W-1:0] BRK_LAST = CNT_W'(BRAKE_CYC - 1);
    localparam logic [2:0] GEAR_MAX = 3'(NUM_GEARS);

    function automatic logic [2:0] sel_gear(input logic am, input logic [2:0] lev,
                                            input logic [2:0] frg);
        sel_gear = (am && lev >= frg) ? frg : lev;
    endfunction

    function automatic logic [2:0] step(input logic [2:0] g, input logic up,
                                        input logic dn);
        if (up && g < GEAR_MAX) begin
            step = g + 3'h1;
        end else if (dn && g > GEAR_MIN) begin
            step = g - 3'h1;
        end else begin
            step = g;
        end
    endfunction

    logic [7:0] ctrl_q;
    logic [15:0] vs_lim_q, ce_lim_q, ee_lim_q;
    logic [7:0] ct_lim_q, et_lim_q;
    logic [2:0] frg_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    dsa_state_e st_q, st_d;
    logic [1:0] dir_q, dir_d, last_q, last_d;
    logic [2:0] gear_q, gear_d;
    logic lamp_q, lamp_d, pend_q, pend_d, seen_q, seen_d;
    logic dn_q, dn_d, lim_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    // apb decode
    wire acc = psel & penable;
    wire wr_en = acc & pready_q & pwrite;
    wire hit = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    wire [31:0] status = {21'h0, lim_q, seen_q, pend_q, st_q, lamp_q, gear_q, dir_q};
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            ADDR_CTRL: rd_mux = {24'h0, ctrl_q};
            ADDR_VS_LIM: rd_mux = {16'h0, vs_lim_q};
            ADDR_CE_LIM: rd_mux = {16'h0, ce_lim_q};
            ADDR_CT_LIM: rd_mux = {24'h0, ct_lim_q};
            ADDR_EE_LIM: rd_mux = {16'h0, ee_lim_q};
            ADDR_ET_LIM: rd_mux = {24'h0, et_lim_q};
            ADDR_FR_GEAR: rd_mux = {29'h0, frg_q};
            ADDR_STATUS: rd_mux = status;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~hit;
            prdata_q <= (acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // R10 safe variant at reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            vs_lim_q <= VS_LIM_RST;
            ce_lim_q <= CE_LIM_RST;
            ct_lim_q <= CT_LIM_RST;
            ee_lim_q <= EE_LIM_RST;
            et_lim_q <= ET_LIM_RST;
            frg_q <= FR_GEAR_RST;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CTRL: ctrl_q <= pwdata[7:0];
                ADDR_VS_LIM: vs_lim_q <= pwdata[15:0];
                ADDR_CE_LIM: ce_lim_q <= pwdata[15:0];
                ADDR_CT_LIM: ct_lim_q <= pwdata[7:0];
                ADDR_EE_LIM: ee_lim_q <= pwdata[15:0];
                ADDR_ET_LIM: et_lim_q <= pwdata[7:0];
                ADDR_FR_GEAR: frg_q <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // R24 policy and check enables
    wire hs = ctrl_q[CTL_HIGH_SPEED];
    // R8 braking variant select
    wire unc = ctrl_q[CTL_UNCOND];
    wire am = ctrl_q[CTL_AUTO];
    wire lev_ok = (lever_dir == FORWARD_DIRECTION) || (lever_dir == REVERSE_DIRECTION);
    wire [1:0] lev = lev_ok ? lever_dir : NEUTRAL_DIRECTION;
    // R14 shared vehicle speed limit
    wire vs_ok = vehicle_speed < vs_lim_q;
    wire ce_ok = ~ctrl_q[CTL_CE_EN] | (engine_speed < ce_lim_q);
    wire ct_ok = ~ctrl_q[CTL_CT_EN] | (throttle_pct < ct_lim_q);
    // R1 R4 change qualification by policy
    wire chg_ok = vs_ok & (hs | (ce_ok & ct_ok));
    // R15 R16 engagement checks
    wire ee_ok = ~ctrl_q[CTL_EE_EN] | (engine_speed < ee_lim_q);
    wire et_ok = ~ctrl_q[CTL_ET_EN] | (throttle_pct < et_lim_q);
    wire eng_ok = vs_ok & ee_ok & et_ok;
    // R20 engagement versus change
    wire engage = (dir_q == NEUTRAL_DIRECTION) & seen_q;
    wire req = lev_ok & (lev != dir_q);
    wire idle_ok = engage ? eng_ok : chg_ok;
    wire neu_ok = pend_q ? eng_ok : chg_ok;
    // R9 R13 braking downshift permission
    wire dn_ok = (gear_q > GEAR_MIN) & (unc | overspeed_free);
    // R19 R21 R22 gear after direction shift
    wire [2:0] new_gear = sel_gear(am, lever_range, frg_q);
    wire [2:0] stepped = step(gear_q, range_up, range_dn);
    wire [CNT_W-1:0] cnt_inc = (cnt_q == BRK_LAST) ? cnt_q : cnt_q + CNT_W'(1);

    always_comb begin
        st_d = st_q;
        dir_d = dir_q;
        gear_d = gear_q;
        lamp_d = lamp_q;
        pend_d = pend_q;
        last_d = last_q;
        cnt_d = cnt_inc;
        dn_d = 1'b0;
        seen_d = seen_q | ((dir_q == NEUTRAL_DIRECTION) & standstill);
        case (st_q)
            DSA_IDLE: begin
                if (!lev_ok) begin
                    dir_d = NEUTRAL_DIRECTION;
                    gear_d = stepped;
                end else if (!req) begin
                    gear_d = stepped;
                end else if (idle_ok) begin
                    dir_d = lev;
                    gear_d = new_gear;
                    last_d = lev;
                    seen_d = 1'b0;
                end else if (engage || !hs || last_q == NEUTRAL_DIRECTION) begin
                    // R23 R17 refusal forces neutral
                    lamp_d = 1'b1;
                    dir_d = NEUTRAL_DIRECTION;
                    pend_d = engage;
                    st_d = DSA_NEU;
                end else begin
                    // R5 re-engage and brake
                    lamp_d = 1'b1;
                    dir_d = last_q;
                    st_d = DSA_BRK;
                    cnt_d = '0;
                    if (dn_ok) begin
                        gear_d = gear_q - 3'h1;
                        dn_d = 1'b1;
                    end
                end
            end
            DSA_NEU: begin
                if (!lev_ok) begin
                    st_d = DSA_IDLE;
                    lamp_d = 1'b0;
                    pend_d = 1'b0;
                    gear_d = stepped;
                end else if (neu_ok) begin
                    // R2 R18 pending shift executes
                    st_d = DSA_IDLE;
                    lamp_d = 1'b0;
                    pend_d = 1'b0;
                    dir_d = lev;
                    gear_d = new_gear;
                    last_d = lev;
                    seen_d = 1'b0;
                end else begin
                    // R3 range steps in neutral
                    gear_d = stepped;
                end
            end
            DSA_BRK: begin
                if (!lev_ok || lev == dir_q) begin
                    st_d = DSA_IDLE;
                    lamp_d = 1'b0;
                    dir_d = lev;
                end else if (vs_ok) begin
                    // R6 change once slow enough
                    st_d = DSA_IDLE;
                    lamp_d = 1'b0;
                    dir_d = lev;
                    gear_d = new_gear;
                    last_d = lev;
                    seen_d = 1'b0;
                end else if (cnt_q == BRK_LAST && dn_ok) begin
                    // R7 R11 R13 R25 next downshift, else hold
                    gear_d = gear_q - 3'h1;
                    dn_d = 1'b1;
                    cnt_d = '0;
                end
            end
            default: begin
                st_d = DSA_IDLE;
                dir_d = NEUTRAL_DIRECTION;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= DSA_IDLE;
            dir_q <= NEUTRAL_DIRECTION;
            last_q <= NEUTRAL_DIRECTION;
            gear_q <= GEAR_MIN;
            lamp_q <= 1'b0;
            pend_q <= 1'b0;
            seen_q <= 1'b0;
            dn_q <= 1'b0;
            lim_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            dir_q <= dir_d;
            last_q <= last_d;
            gear_q <= gear_d;
            lamp_q <= lamp_d;
            pend_q <= pend_d;
            seen_q <= seen_d;
            dn_q <= dn_d;
            // R12 engine limit request when stuck
            lim_q <= ctrl_q[CTL_TSC_EN] & (st_d == DSA_BRK) & ~unc & ~overspeed_free;
            cnt_q <= cnt_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dir_out = dir_q;
    assign gear_out = gear_q;
    assign warn_lamp = lamp_q;
    assign brake_dn = dn_q;
    assign spd_lim_req = lim_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    wire idle_req = (st_q == DSA_IDLE) & req;
    sequence refused_low;
        idle_req & ~engage & ~chg_ok & ~hs;
    endsequence
    lo_refuse_a: assert property (refused_low |=> dir_q == NEUTRAL_DIRECTION && lamp_q) // R1
        else $error("low-speed refusal did not force neutral");
    neu_hold_a: assert property ((st_q == DSA_NEU) & lev_ok & ~neu_ok
        |=> dir_q == NEUTRAL_DIRECTION && st_q == DSA_NEU) // R2
        else $error("neutral not held while pending");
    neu_range_a: assert property ((st_q == DSA_NEU) & lev_ok & ~neu_ok & range_up
        & ~range_dn & (gear_q < GEAR_MAX) |=> gear_q == $past(gear_q) + 3'h1) // R3
        else $error("range upshift lost in forced neutral");
    hs_vs_a: assert property (idle_req & ~engage & hs & vs_ok
        |=> dir_q == $past(lev) && st_q == DSA_IDLE) // R4
        else $error("high-speed change blocked by other check");
    sequence brake_entry;
        idle_req & ~engage & hs & ~vs_ok & (last_q != NEUTRAL_DIRECTION);
    endsequence
    hs_brake_a: assert property (brake_entry |=> st_q == DSA_BRK && dir_q == $past(last_q)
        && lamp_q && brake_dn == $past(dn_ok)) // R5
        else $error("braking entry wrong");
    brk_exit_a: assert property ((st_q == DSA_BRK) & lev_ok & (lev != dir_q) & vs_ok
        |=> dir_q == $past(lev) && !lamp_q) // R6
        else $error("change not executed below limit");
    brk_next_a: assert property ((st_q == DSA_BRK) & lev_ok & (lev != dir_q) & ~vs_ok
        & (cnt_q == BRK_LAST) & dn_ok |=> brake_dn && gear_q == $past(gear_q) - 3'h1) // R7
        else $error("no further braking downshift after delay");
    safe_hold_a: assert property ((st_q == DSA_BRK) & lev_ok & (lev != dir_q) & ~vs_ok
        & ~unc & ~overspeed_free |=> !brake_dn && gear_q == $past(gear_q)
        && dir_q == $past(dir_q)) // R11
        else $error("safe variant changed gear or direction");
    lim_req_a: assert property (spd_lim_req
        |-> st_q == DSA_BRK && $past(ctrl_q[CTL_TSC_EN])) // R12
        else $error("engine limit request outside enabled braking");
    cnt_clr_a: assert property (brake_dn |-> cnt_q == '0) // R25
        else $error("delay counter not cleared at downshift");
    eng_ref_a: assert property (idle_req & engage & ~eng_ok
        |=> dir_q == NEUTRAL_DIRECTION && lamp_q && pend_q) // R17
        else $error("refused engagement not held in neutral");
    lamp_off_a: assert property ((st_q == DSA_NEU) & pend_q & lev_ok & eng_ok
        |=> !lamp_q && dir_q == $past(lev)) // R18
        else $error("engagement not granted with lamp off");
    gear_sel_a: assert property (idle_req & idle_ok
        |=> gear_q == $past(sel_gear(am, lever_range, frg_q))) // R21
        else $error("wrong gear after direction shift");
endmodule
`default_nettype wire

// File: hdl/dsa_pkg.sv
// constants of the direction shift arbiter
// What this block does
// R1 - low-speed policy refuses change on high speed, engine speed, throttle; forces neutral
// R2 - refused low-speed change holds neutral until conditions pass, then executes
// R3 - range up and down steps still run while neutral is forced
// R4 - high-speed policy qualifies a direction change on vehicle speed only
// R5 - high-speed refusal re-engages original direction and downshifts for engine braking
// R6 - during braking the pending change executes once vehicle speed is below limit
// R7 - speed still high two seconds after a braking downshift gives another downshift
// R8 - braking downshifts are configurable as safe or unconditional
// R9 - safe variant downshifts only when the lower gear has no overspeed risk
// R10 - safe variant is the reset default
// R11 - safe variant with nothing permitted leaves direction and gear unchanged
// R12 - optional engine speed limit request while stuck in opposite direction
// R13 - unconditional variant downshifts without overspeed check, fixed delay apart
// R14 - engagement from neutral checks the direction change vehicle speed limit
// R15 - engagement optionally requires engine speed below its own limit
// R16 - engagement optionally requires throttle percentage below its own limit
// R17 - any violated enabled engagement condition keeps the transmission in neutral
// R18 - refused engagement keeps lamp on until all pass, then engages, lamp off
// R19 - gear after engagement is chosen like after a direction change
// R20 - neutral to drive is engagement if standstill seen in neutral, else change
// R21 - automatic mode with lever range at or above set gear selects that gear
// R22 - manual mode or lever range below set gear selects lever range
// R23 - refused change lights lamp and forces neutral or brakes by policy
// R24 - configuration selects policy; separate enables govern each optional check
// R25 - conditions re-evaluated every tick; braking delay counter cleared at downshift
package dsa_pkg;
    localparam logic [1:0] NEUTRAL_DIRECTION = 2'h0;
    localparam logic [1:0] FORWARD_DIRECTION = 2'h1;
    localparam logic [1:0] REVERSE_DIRECTION = 2'h2;
    localparam logic [2:0] GEAR_MIN = 3'h1;
    localparam int unsigned NUM_GEARS_DEF = 4;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BRAKE_DELAY_MS = 2000;
    localparam int unsigned BRAKE_CYC_DEF = BRAKE_DELAY_MS * (CLK_HZ / 1000);
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VS_LIM = 8'h04;
    localparam logic [7:0] ADDR_CE_LIM = 8'h08;
    localparam logic [7:0] ADDR_CT_LIM = 8'h0C;
    localparam logic [7:0] ADDR_EE_LIM = 8'h10;
    localparam logic [7:0] ADDR_ET_LIM = 8'h14;
    localparam logic [7:0] ADDR_FR_GEAR = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam int CTL_HIGH_SPEED = 0;
    localparam int CTL_UNCOND = 1;
    localparam int CTL_CE_EN = 2;
    localparam int CTL_CT_EN = 3;
    localparam int CTL_EE_EN = 4;
    localparam int CTL_ET_EN = 5;
    localparam int CTL_AUTO = 6;
    localparam int CTL_TSC_EN = 7;
    localparam logic [7:0] CTRL_RST = 8'h4C;
    localparam logic [15:0] VS_LIM_RST = 16'h0008;
    localparam logic [15:0] CE_LIM_RST = 16'h0400;
    localparam logic [7:0] CT_LIM_RST = 8'h05;
    localparam logic [15:0] EE_LIM_RST = 16'h0400;
    localparam logic [7:0] ET_LIM_RST = 8'h05;
    localparam logic [2:0] FR_GEAR_RST = 3'h2;
    typedef enum logic [1:0] {
        DSA_IDLE = 2'b00,
        DSA_NEU = 2'b01,
        DSA_BRK = 2'b11
    } dsa_state_e;
endpackage

// File: sim/direction_shift_arbiter_tb.sv
// self-checking bench of the direction shift arbiter
`timescale 1ns/10ps
`default_nettype none
module direction_shift_arbiter_tb
    import dsa_pkg::*;
;
    localparam int unsigned BC = 20;
    typedef struct {
        logic [7:0] c;
        logic [1:0] d;
        logic [2:0] r;
        logic [15:0] s;
        logic [15:0] e;
        logic [7:0] t;
        logic ss;
        logic [1:0] ed;
        logic [2:0] eg;
        logic [1:0] el;
    } dsa_row_s;
    dsa_row_s rows [16];
    logic [31:0] rst_v [7];
    logic clk_sys, nrst, psel, penable, pwrite, pslverr, pready, range_up, range_dn;
    logic [7:0] paddr, cmd_thr, throttle_pct;
    logic [31:0] pwdata, prdata;
    logic [1:0] cmd_dir, lever_dir, dir_out;
    logic [2:0] cmd_rng, lever_range, gear_out;
    logic [15:0] cmd_spd, cmd_eng, vehicle_speed, engine_speed;
    logic cmd_ss, cmd_osf, standstill, overspeed_free, warn_lamp, brake_dn, spd_lim_req;
    int failures = 0;
    int n_tests = 0;
    dsa_arbiter #(.NUM_GEARS(4), .BRAKE_CYC(BC)) dsa_arbiter_i (.clk_sys(clk_sys),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lever_dir(lever_dir), .lever_range(lever_range), .vehicle_speed(vehicle_speed),
        .engine_speed(engine_speed), .throttle_pct(throttle_pct), .standstill(standstill),
        .overspeed_free(overspeed_free), .range_up(range_up), .range_dn(range_dn),
        .dir_out(dir_out), .gear_out(gear_out), .warn_lamp(warn_lamp), .brake_dn(brake_dn),
        .spd_lim_req(spd_lim_req));
    dsa_lever_model dsa_lever_model_i (.clk_sys(clk_sys), .cmd_dir(cmd_dir),
        .cmd_rng(cmd_rng), .cmd_spd(cmd_spd), .cmd_eng(cmd_eng), .cmd_thr(cmd_thr),
        .cmd_ss(cmd_ss), .cmd_osf(cmd_osf), .lever_dir(lever_dir), .lever_range(lever_range),
        .vehicle_speed(vehicle_speed), .engine_speed(engine_speed),
        .throttle_pct(throttle_pct), .standstill(standstill), .overspeed_free(overspeed_free));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic setctl(input logic [7:0] c);
        logic [31:0] rd;
        logic err;
        apb(1'b1, ADDR_CTRL, {24'h0, c}, rd, err);
    endtask
    task automatic drive(input logic [1:0] d, input logic [2:0] r, input logic [15:0] s,
            input logic [15:0] e, input logic [7:0] t, input logic ss);
        cmd_dir <= d;
        cmd_rng <= r;
        cmd_spd <= s;
        cmd_eng <= e;
        cmd_thr <= t;
        cmd_ss <= ss;
        tick(4);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        int k, t1, t2;
        logic [31:0] rd;
        logic err;
        logic [2:0] g;
        nrst = 1'b0;
        {psel, penable, pwrite, range_up, range_dn, cmd_ss} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        {cmd_dir, cmd_spd, cmd_eng, cmd_thr} = 42'h0;
        cmd_rng = 3'h1;
        cmd_osf = 1'b1;
        rst_v = '{32'h4C, 32'h8, 32'h400, 32'h5, 32'h400, 32'h5, 32'h2};
        rows = '{
            '{8'h4C, 2'h3, 3'h4, 16'h0, 16'h100, 8'h0, 1'h1, 2'h0, 3'h0, 2'h0},
            '{8'h4C, 2'h1, 3'h4, 16'h0, 16'h100, 8'h0, 1'h1, 2'h1, 3'h2, 2'h0},
            '{8'h4C, 2'h2, 3'h4, 16'h14, 16'h100, 8'h0, 1'h0, 2'h0, 3'h0, 2'h1},
            '{8'h4C, 2'h2, 3'h4, 16'h0, 16'h100, 8'hA, 1'h0, 2'h0, 3'h0, 2'h1},
            '{8'h4C, 2'h2, 3'h4, 16'h0, 16'h500, 8'h0, 1'h0, 2'h0, 3'h0, 2'h1},
            '{8'h4C, 2'h2, 3'h1, 16'h0, 16'h100, 8'h0, 1'h0, 2'h2, 3'h1, 2'h0},
            '{8'h4C, 2'h0, 3'h1, 16'h14, 16'h100, 8'h0, 1'h0, 2'h0, 3'h0, 2'h0},
            '{8'h4C, 2'h1, 3'h4, 16'h0, 16'h500, 8'h0, 1'h0, 2'h0, 3'h0, 2'h1},
            '{8'h4C, 2'h0, 3'h4, 16'h0, 16'h100, 8'h0, 1'h1, 2'h0, 3'h0, 2'h2},
            '{8'h3C, 2'h0, 3'h4, 16'h0, 16'h100, 8'h0, 1'h1, 2'h0, 3'h0, 2'h2},
            '{8'h3C, 2'h2, 3'h3, 16'h0, 16'h500, 8'h0, 1'h1, 2'h0, 3'h0, 2'h1},
            '{8'h3C, 2'h2, 3'h3, 16'h0, 16'h100, 8'h9, 1'h1, 2'h0, 3'h0, 2'h1},
            '{8'h3C, 2'h2, 3'h3, 16'h9, 16'h100, 8'h0, 1'h0, 2'h0, 3'h0, 2'h1},
            '{8'h3C, 2'h2, 3'h3, 16'h0, 16'h100, 8'h0, 1'h1, 2'h2, 3'h3, 2'h0},
            '{8'h0D, 2'h1, 3'h3, 16'h14, 16'h500, 8'h32, 1'h0, 2'h2, 3'h0, 2'h1},
            '{8'h0D, 2'h1, 3'h3, 16'h0, 16'h500, 8'h32, 1'h0, 2'h1, 3'h3, 2'h0}};
        tick(2);
        check("rst dir", 32'(dir_out), 32'h0);
        check("rst gear", 32'(gear_out), 32'h1);
        check("rst out", 32'({warn_lamp, brake_dn, spd_lim_req}), 32'h0);
        nrst <= 1'b1;
        for (k = 0; k < 7; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0, rd, err);
            check("reg reset", rd, rst_v[k]);
            check("reg err", 32'(err), 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0, rd, err);
        check("unmapped", {rd[30:0], err}, 32'h1);
        for (k = 0; k < 16; k++) begin
            setctl(rows[k].c);
            drive(rows[k].d, rows[k].r, rows[k].s, rows[k].e, rows[k].t, rows[k].ss);
            check("row dir", 32'(dir_out), 32'(rows[k].ed));
            if (rows[k].eg != 3'h0) begin
                check("row gear", 32'(gear_out), 32'(rows[k].eg));
            end
            if (rows[k].el != 2'h2) begin
                check("row lamp", 32'(warn_lamp), 32'(rows[k].el));
            end
        end
        setctl(8'h4C);
        drive(2'h2, 3'h3, 16'h14, 16'h100, 8'h0, 1'h0);
        g = gear_out;
        range_dn <= 1'b1;
        tick(1);
        range_dn <= 1'b0;
        tick(3);
        check("neutral step", 32'(gear_out), 32'(g - 3'h1));
        range_up <= 1'b1;
        tick(1);
        range_up <= 1'b0;
        tick(3);
        check("neutral up", 32'(gear_out), 32'(g));
        setctl(8'h0F);
        drive(2'h0, 3'h4, 16'h0, 16'h100, 8'h0, 1'h1);
        drive(2'h1, 3'h4, 16'h0, 16'h100, 8'h0, 1'h1);
        check("engage g4", 32'({dir_out, gear_out}), 32'h0C);
        cmd_osf <= 1'b0;
        cmd_dir <= 2'h2;
        cmd_spd <= 16'h14;
        cmd_ss <= 1'b0;
        t1 = -1;
        t2 = -1;
        for (k = 0; k < 100 && t2 < 0; k++) begin
            @(posedge clk_sys);
            if (brake_dn === 1'b1 && t1 < 0) t1 = k;
            else if (brake_dn === 1'b1) t2 = k;
        end
        tick(2);
        check("brake gap", 32'(t2 - t1), 32'(BC));
        check("brake hold", 32'({warn_lamp, dir_out, gear_out}), 32'h2A);
        drive(2'h2, 3'h4, 16'h0, 16'h100, 8'h0, 1'h0);
        check("brake end", 32'({warn_lamp, dir_out}), 32'h2);
        drive(2'h1, 3'h4, 16'h0, 16'h500, 8'h32, 1'h0);
        check("hs change", 32'({warn_lamp, dir_out, gear_out}), 32'h0C);
        setctl(8'h8D);
        drive(2'h2, 3'h4, 16'h14, 16'h100, 8'h0, 1'h0);
        g = gear_out;
        t1 = 0;
        for (k = 0; k < 30; k++) begin
            @(posedge clk_sys);
            if (brake_dn === 1'b1) t1++;
        end
        check("safe none", 32'(t1), 32'h0);
        check("safe hold", 32'({spd_lim_req, warn_lamp, dir_out, gear_out}),
            {27'h0, 4'hD, g});
        cmd_osf <= 1'b1;
        for (k = 0; k < 30 && brake_dn !== 1'b1; k++) tick(1);
        check("safe brake", 32'(brake_dn), 32'h1);
        tick(2);
        check("limit off", 32'(spd_lim_req), 32'h0);
        apb(1'b1, ADDR_VS_LIM, 32'h1234, rd, err);
        apb(1'b0, ADDR_VS_LIM, 32'h0, rd, err);
        check("vs limit", {rd[30:0], err}, 32'h2468);
        nrst <= 1'b0;
        tick(2);
        check("mid rst", 32'({warn_lamp, brake_dn, spd_lim_req, dir_out, gear_out}),
            32'h1);
        nrst <= 1'b1;
        apb(1'b0, ADDR_VS_LIM, 32'h0, rd, err);
        check("vs reset", rd, 32'(VS_LIM_RST));
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: sim/dsa_lever_model.sv
// shift lever and sensor model feeding the arbiter
`timescale 1ns/10ps
`default_nettype none
module dsa_lever_model (
    input wire logic clk_sys,
    input wire logic [1:0] cmd_dir,
    input wire logic [2:0] cmd_rng,
    input wire logic [15:0] cmd_spd,
    input wire logic [15:0] cmd_eng,
    input wire logic [7:0] cmd_thr,
    input wire logic cmd_ss,
    input wire logic cmd_osf,
    output logic [1:0] lever_dir,
    output logic [2:0] lever_range,
    output logic [15:0] vehicle_speed,
    output logic [15:0] engine_speed,
    output logic [7:0] throttle_pct,
    output logic standstill,
    output logic overspeed_free
);
    // lever and sensors refresh once per tick
    always @(posedge clk_sys) begin
        lever_dir <= cmd_dir;
        lever_range <= cmd_rng;
        vehicle_speed <= cmd_spd;
        engine_speed <= cmd_eng;
        throttle_pct <= cmd_thr;
        standstill <= cmd_ss;
        overspeed_free <= cmd_osf;
    end
endmodule
`default_nettype wire
